// ---- inc/ctr_pkg.sv ----
`default_nettype none
package ctr_pkg;

	// Counter widths
	localparam int PACER_WIDTH = 24;                 // Sample-pacing counter
	localparam int GP_WIDTH    = 16;                 // General-purpose counter
	localparam int ADDR_WIDTH  = 4;                  // I/O offset within the block
	localparam int DATA_WIDTH  = 8;                  // Byte-wide I/O data
	localparam int STAGE_BYTES = 3;                  // Data registers at 12..14

	// Register offsets
	localparam logic [3:0] OFS_RATE      = 4'h9;     // Pacer clock rate select
	localparam logic [3:0] OFS_DATA_LOW  = 4'hc;     // Low data byte
	localparam logic [3:0] OFS_DATA_MID  = 4'hd;     // Middle data byte
	localparam logic [3:0] OFS_DATA_HIGH = 4'he;     // High data byte
	localparam logic [3:0] OFS_COMMAND   = 4'hf;     // Write-only command

	// Field positions and values
	localparam int         RATE_SEL_BIT  = 3;        // pacer_clock_rate_select
	localparam logic       SEL_PACER     = 1'b0;     // counter_select value
	localparam logic       SEL_GP        = 1'b1;     // counter_select value
	localparam logic [1:0] BYTE_LOW      = 2'h0;     // Byte index, low
	localparam logic [1:0] BYTE_MID      = 2'h1;     // Byte index, middle
	localparam logic [1:0] BYTE_HIGH     = 2'h2;     // Byte index, high

	// Reset and idle values
	localparam logic [7:0] RDATA_RESET   = 8'h00;    // Read data after reset
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;    // Answer to other offsets
	localparam logic [7:0] STAGE_RESET   = 8'h00;    // Staged load bytes

	// Timing: periods in ns, divisors derived
	localparam int SYS_PERIOD_NS  = 10;              // 100 MHz system clock
	localparam int FAST_PERIOD_NS = 100;             // 10 MHz counting clock
	localparam int SLOW_PERIOD_NS = 1000;            // 1 MHz counting clock
	localparam int FAST_DIV       = FAST_PERIOD_NS / SYS_PERIOD_NS;
	localparam int SLOW_DIV       = SLOW_PERIOD_NS / FAST_PERIOD_NS;
	localparam int PRESCALE_WIDTH = 4;               // Holds FAST_DIV and SLOW_DIV

	// Command byte, bit 7 down to bit 0
	typedef struct packed {
		logic counter_select;                        // 0 pacer, 1 general purpose
		logic latch_cmd;                             // Capture value for reading
		logic gate_off_cmd;                          // Ignore gate input
		logic gate_on_cmd;                           // Count only while gate high
		logic count_stop_cmd;                        // Disable counting
		logic count_run_cmd;                         // Enable counting
		logic load_cmd;                              // Copy staged value
		logic zero_cmd;                              // Set count to zero
	} cmd_t;

	// Byte of a latched value by index
	function automatic logic [7:0] byte_pick(input logic [23:0] value,
		input logic [1:0] idx);
		byte_pick = value[idx * 8 +: 8];
	endfunction : byte_pick

endpackage : ctr_pkg
`default_nettype wire

// ---- logic/down_counter.sv ----
`timescale 1ns/10ps
`default_nettype none
module down_counter import ctr_pkg::*; #(
	parameter int WIDTH = GP_WIDTH                    // Counter width in bits
) (
	input  wire logic             sys_clk,            // System clock
	input  wire logic             resetn,             // Synchronous reset, low
	input  wire logic             tick,               // Counting clock edge
	input  wire logic             gate,               // Gate input level
	input  wire logic             cmd_hit,            // Command for this counter
	input  wire cmd_t             cmd,                // Decoded command byte
	input  wire logic [WIDTH-1:0] load_value,         // Staged load value
	output logic      [WIDTH-1:0] count_q,            // Current count
	output logic      [WIDTH-1:0] initial_q,          // Reload value
	output logic      [WIDTH-1:0] latched_q,          // Value held for reading
	output logic                  running_q,          // Counter enabled
	output logic                  gated_q,            // Gating enabled
	output logic                  pulse_q             // Terminal-count pulse
);

	// Refuse widths the byte path cannot carry
	if (WIDTH < 2 || WIDTH > PACER_WIDTH) begin : g_bad_width
		$error("down_counter WIDTH out of range");
	end

	localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1}; // Last step

	logic [WIDTH-1:0] count_d;                        // Next count
	logic [WIDTH-1:0] initial_d;                      // Next reload value
	logic [WIDTH-1:0] latched_d;                      // Next latched value
	logic             running_d;                      // Next enable
	logic             gated_d;                        // Next gating
	logic             pulse_d;                        // Next pulse
	logic             counting;                       // Edge that counts

	// Next state: counting first, commands then override in fixed order
	always_comb begin
		count_d   = count_q;
		initial_d = initial_q;
		latched_d = latched_q;
		running_d = running_q;
		gated_d   = gated_q;
		pulse_d   = pulse_q;
		counting  = tick && running_q && (!gated_q || gate);
		// Pulse lasts one counting-clock period
		if (tick) begin
			pulse_d = 1'b0;
		end
		if (counting) begin
			// Zero after a clear also reloads, so a cleared counter restarts
			if (count_q <= ONE) begin
				count_d = initial_q;
				pulse_d = 1'b1;
			end else begin
				count_d = count_q - ONE;
			end
		end
		if (cmd_hit) begin
			if (cmd.load_cmd) begin
				initial_d = load_value;
				count_d   = load_value;
			end
			if (cmd.zero_cmd) begin
				count_d = '0;
			end
			// Both of a pair set cancels out
			if (cmd.count_run_cmd != cmd.count_stop_cmd) begin
				running_d = cmd.count_run_cmd;
			end
			if (cmd.gate_on_cmd != cmd.gate_off_cmd) begin
				gated_d = cmd.gate_on_cmd;
			end
			// Latch sees the result of the earlier actions
			if (cmd.latch_cmd) begin
				latched_d = count_d;
			end
		end
	end

	// State registers
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			count_q   <= '0;
			initial_q <= '0;
			latched_q <= '0;
			running_q <= 1'b0;
			gated_q   <= 1'b0;
			pulse_q   <= 1'b0;
		end else begin
			count_q   <= count_d;
			initial_q <= initial_d;
			latched_q <= latched_d;
			running_q <= running_d;
			gated_q   <= gated_d;
			pulse_q   <= pulse_d;
		end
	end

endmodule : down_counter
`default_nettype wire

// ---- logic/ctr_cmd_port.sv ----
// What this block does
// - Command bit 7 selects counter; bits 6..0 act
// - Pacer loads three bytes, general counter two
// - Load bytes staged at 12..14, any order
// - Load command copies staged value as count
// - Enable or disable anytime; disabled holds value
// - Gating on counts only while gate high
// - Latch captures value; counter keeps running
// - Data reads return latched bytes
// - Clear zeroes counter; enabled one keeps counting
// - Both count down; pacer 24 bits
// - Last step reloads and starts a one-period pulse
// - Pacer clock 10 or 1 MHz by bit
`timescale 1ns/10ps
`default_nettype none
module ctr_cmd_port import ctr_pkg::*; (
	input  wire logic                  sys_clk,       // 100 MHz system clock
	input  wire logic                  resetn,        // Synchronous reset, low
	input  wire logic [ADDR_WIDTH-1:0] io_addr,       // I/O offset
	input  wire logic [DATA_WIDTH-1:0] io_wdata,      // I/O write data
	input  wire logic                  io_wr,         // Write strobe, one cycle
	input  wire logic                  io_rd,         // Read strobe, one cycle
	input  wire logic                  pacer_gate,    // Pacer gate input
	input  wire logic                  gp_gate,       // General counter gate
	output logic      [DATA_WIDTH-1:0] io_rdata_q,    // Read data, next cycle
	output logic                       pacer_pulse,   // Pacer terminal pulse
	output logic                       gp_pulse       // General terminal pulse
);

	// Write decode
	logic wr_cmd;                                     // Command register write
	logic wr_rate;                                    // Rate register write
	cmd_t cmd;                                        // Command byte as fields
	logic pacer_hit;                                  // Command for pacer
	logic gp_hit;                                     // Command for general

	assign wr_cmd    = io_wr && (io_addr == OFS_COMMAND);
	assign wr_rate   = io_wr && (io_addr == OFS_RATE);
	assign cmd       = cmd_t'(io_wdata);
	assign pacer_hit = wr_cmd && (cmd.counter_select == SEL_PACER);
	assign gp_hit    = wr_cmd && (cmd.counter_select == SEL_GP);

	// Staged load bytes, one register per data offset
	logic [DATA_WIDTH-1:0] stage_q [STAGE_BYTES];     // Staged bytes
	logic [DATA_WIDTH-1:0] stage_d [STAGE_BYTES];     // Next staged bytes

	for (genvar i = 0; i < STAGE_BYTES; i++) begin : g_stage
		// Each byte written on its own, so order does not matter
		always_comb begin
			stage_d[i] = stage_q[i];
			if (io_wr && (io_addr == OFS_DATA_LOW + 4'(i))) begin
				stage_d[i] = io_wdata;
			end
		end

		always_ff @(posedge sys_clk) begin
			if (!resetn) begin
				stage_q[i] <= STAGE_RESET;
			end else begin
				stage_q[i] <= stage_d[i];
			end
		end
	end

	// Load values assembled from the staged bytes
	logic [PACER_WIDTH-1:0] pacer_load;               // Low, middle, high
	logic [GP_WIDTH-1:0]    gp_load;                  // Low, high at 12 and 13

	assign pacer_load = {stage_q[BYTE_HIGH], stage_q[BYTE_MID], stage_q[BYTE_LOW]};
	assign gp_load    = {stage_q[BYTE_MID], stage_q[BYTE_LOW]};

	// Pacer clock rate bit; other bits of that offset belong elsewhere
	logic rate_q;                                     // 1 selects 1 MHz
	logic rate_d;                                     // Next rate bit

	always_comb begin
		rate_d = rate_q;
		if (wr_rate) begin
			rate_d = io_wdata[RATE_SEL_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rate_q <= 1'b0;
		end else begin
			rate_q <= rate_d;
		end
	end

	// Counting clocks from the system clock as enable ticks
	logic [PRESCALE_WIDTH-1:0] fast_cnt_q;            // Divides to 10 MHz
	logic [PRESCALE_WIDTH-1:0] fast_cnt_d;
	logic [PRESCALE_WIDTH-1:0] slow_cnt_q;            // Divides fast to 1 MHz
	logic [PRESCALE_WIDTH-1:0] slow_cnt_d;
	logic                      fast_tick_q;           // 10 MHz tick
	logic                      fast_tick_d;
	logic                      slow_tick_q;           // 1 MHz tick
	logic                      slow_tick_d;
	logic                      pacer_tick;            // Selected pacer tick

	localparam logic [PRESCALE_WIDTH-1:0] FAST_LAST = PRESCALE_WIDTH'(FAST_DIV - 1);
	localparam logic [PRESCALE_WIDTH-1:0] SLOW_LAST = PRESCALE_WIDTH'(SLOW_DIV - 1);

	// Prescalers; ticks stay one system cycle wide
	always_comb begin
		fast_cnt_d  = fast_cnt_q + 4'h1;
		slow_cnt_d  = slow_cnt_q;
		fast_tick_d = 1'b0;
		slow_tick_d = 1'b0;
		if (fast_cnt_q == FAST_LAST) begin
			fast_cnt_d  = '0;
			fast_tick_d = 1'b1;
			slow_cnt_d  = slow_cnt_q + 4'h1;
			if (slow_cnt_q == SLOW_LAST) begin
				slow_cnt_d  = '0;
				slow_tick_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			fast_cnt_q  <= '0;
			slow_cnt_q  <= '0;
			fast_tick_q <= 1'b0;
			slow_tick_q <= 1'b0;
		end else begin
			fast_cnt_q  <= fast_cnt_d;
			slow_cnt_q  <= slow_cnt_d;
			fast_tick_q <= fast_tick_d;
			slow_tick_q <= slow_tick_d;
		end
	end

	// A rate change takes effect at the next tick of the new clock
	assign pacer_tick = rate_q ? slow_tick_q : fast_tick_q;

	// The two counters
	logic [PACER_WIDTH-1:0] pacer_count;              // Pacer count
	logic [PACER_WIDTH-1:0] pacer_initial;            // Pacer reload value
	logic [PACER_WIDTH-1:0] pacer_latched;            // Pacer latched value
	logic                   pacer_running;            // Pacer enabled
	logic                   pacer_gated;              // Pacer gating on
	logic [GP_WIDTH-1:0]    gp_count;                 // General count
	logic [GP_WIDTH-1:0]    gp_initial;               // General reload value
	logic [GP_WIDTH-1:0]    gp_latched;               // General latched value
	logic                   gp_running;               // General enabled
	logic                   gp_gated;                 // General gating on

	down_counter #(
		.WIDTH      (PACER_WIDTH)
	) u_pacer (
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.tick       (pacer_tick),
		.gate       (pacer_gate),
		.cmd_hit    (pacer_hit),
		.cmd        (cmd),
		.load_value (pacer_load),
		.count_q    (pacer_count),
		.initial_q  (pacer_initial),
		.latched_q  (pacer_latched),
		.running_q  (pacer_running),
		.gated_q    (pacer_gated),
		.pulse_q    (pacer_pulse)
	);

	// General counter runs from the 10 MHz clock
	down_counter #(
		.WIDTH      (GP_WIDTH)
	) u_gp (
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.tick       (fast_tick_q),
		.gate       (gp_gate),
		.cmd_hit    (gp_hit),
		.cmd        (cmd),
		.load_value (gp_load),
		.count_q    (gp_count),
		.initial_q  (gp_initial),
		.latched_q  (gp_latched),
		.running_q  (gp_running),
		.gated_q    (gp_gated),
		.pulse_q    (gp_pulse)
	);

	// Which counter the data registers show: the last one latched
	logic read_sel_q;                                 // counter_select of latch
	logic read_sel_d;

	always_comb begin
		read_sel_d = read_sel_q;
		if (wr_cmd && cmd.latch_cmd) begin
			read_sel_d = cmd.counter_select;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			read_sel_q <= SEL_PACER;
		end else begin
			read_sel_q <= read_sel_d;
		end
	end

	// Read mux; the command register is write-only and reads as unmapped
	logic [DATA_WIDTH-1:0]  rdata_d;                  // Next read data
	logic [PACER_WIDTH-1:0] read_value;               // Latched value shown

	assign read_value = (read_sel_q == SEL_GP) ? PACER_WIDTH'(gp_latched) : pacer_latched;

	always_comb begin
		rdata_d = io_rdata_q;
		if (io_rd) begin
			case (io_addr)
				OFS_DATA_LOW:  rdata_d = byte_pick(read_value, BYTE_LOW);
				OFS_DATA_MID:  rdata_d = byte_pick(read_value, BYTE_MID);
				// General counter has no high byte; zero-extended reads 0
				OFS_DATA_HIGH: rdata_d = byte_pick(read_value, BYTE_HIGH);
				default:       rdata_d = UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			io_rdata_q <= RDATA_RESET;
		end else begin
			io_rdata_q <= rdata_d;
		end
	end

	// Helper terms for the checks below
	logic pacer_event;                                // Pacer counts this cycle
	assign pacer_event = pacer_tick && pacer_running && (!pacer_gated || pacer_gate);

	AST_LOAD_COPIES: assert property (@(posedge sys_clk) disable iff (!resetn)
		pacer_hit && cmd.load_cmd && !cmd.zero_cmd |=>
		pacer_count == $past(pacer_load) && pacer_initial == $past(pacer_load))
		else $error("load did not copy staged value");

	AST_CLEAR_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
		gp_hit && cmd.zero_cmd |=> gp_count == '0)
		else $error("clear did not zero counter");

	AST_STOP_HOLDS: assert property (@(posedge sys_clk) disable iff (!resetn)
		!pacer_running && !pacer_hit |=> $stable(pacer_count))
		else $error("disabled counter changed");

	AST_GATE_LOW_HOLDS: assert property (@(posedge sys_clk) disable iff (!resetn)
		gp_running && gp_gated && !gp_gate && !gp_hit |=> $stable(gp_count))
		else $error("gated counter counted with gate low");

	AST_COUNT_DOWN: assert property (@(posedge sys_clk) disable iff (!resetn)
		pacer_event && !pacer_hit && pacer_count > 24'h000001 |=>
		pacer_count == $past(pacer_count) - 24'h000001 && !pacer_pulse)
		else $error("counter did not step down by one");

	AST_RELOAD_PULSE: assert property (@(posedge sys_clk) disable iff (!resetn)
		pacer_event && !pacer_hit && pacer_count <= 24'h000001 |=>
		pacer_pulse && pacer_count == pacer_initial ##1 pacer_pulse[*8])
		else $error("terminal count did not pulse and reload");

	AST_LATCH_RUNS: assert property (@(posedge sys_clk) disable iff (!resetn)
		gp_hit && cmd.latch_cmd && !cmd.load_cmd && !cmd.zero_cmd |=>
		gp_latched == gp_count && gp_running == $past(gp_running))
		else $error("latch missed value or stopped counter");

	AST_READ_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
		io_rd && io_addr == OFS_DATA_LOW |=> io_rdata_q == $past(read_value[7:0]))
		else $error("low byte read wrong");

	AST_STAGE_ANY: assert property (@(posedge sys_clk) disable iff (!resetn)
		io_wr && io_addr == OFS_DATA_MID |=> gp_load[15:8] == $past(io_wdata))
		else $error("staged byte not stored");

	// The other counter must keep its enable, whatever it was
	AST_SELECT: assert property (@(posedge sys_clk) disable iff (!resetn)
		gp_hit && cmd.count_run_cmd && !cmd.count_stop_cmd |=>
		gp_running && pacer_running == $past(pacer_running))
		else $error("command reached wrong counter");

	AST_PAIR_CANCELS: assert property (@(posedge sys_clk) disable iff (!resetn)
		pacer_hit && cmd.gate_on_cmd && cmd.gate_off_cmd |=> $stable(pacer_gated))
		else $error("opposing gate bits took effect");

	// A slow tick must fall where the slow prescaler wraps
	AST_SLOW_RATE: assert property (@(posedge sys_clk) disable iff (!resetn)
		rate_q && pacer_tick && !wr_rate |-> slow_cnt_q == '0 ##1 !pacer_tick[*8])
		else $error("slow pacer clock ticked too often");

endmodule : ctr_cmd_port
`default_nettype wire

// ---- dv/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host side of the I/O bus; strobes last one cycle, launched on falling edges
module host_model import ctr_pkg::*; (
	input  wire logic                  sys_clk,   // System clock
	output logic      [ADDR_WIDTH-1:0] io_addr,   // Offset driven
	output logic      [DATA_WIDTH-1:0] io_wdata,  // Write data
	output logic                       io_wr,     // Write strobe
	output logic                       io_rd      // Read strobe
);
	// Idle bus at time zero
	initial begin
		io_addr  = 4'h0;
		io_wdata = 8'h00;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
	end
	// One access; released lines show the inverse so stale values never match
	task automatic access(input logic [3:0] a, input logic [7:0] d, input logic w);
		@(negedge sys_clk);
		io_addr  = a;
		io_wdata = d;
		io_wr    = w;
		io_rd    = ~w;
		@(negedge sys_clk);
		io_wr    = 1'b0;
		io_rd    = 1'b0;
		io_addr  = ~a;
		io_wdata = ~d;
	endtask : access
	// Start: load, optional gate, then enable
	task automatic start(input logic sel, input logic gated);
		access(OFS_COMMAND, {sel, 7'h02}, 1'b1);
		if (gated) begin
			access(OFS_COMMAND, {sel, 7'h10}, 1'b1);
		end
		access(OFS_COMMAND, {sel, 7'h04}, 1'b1);
	endtask : start
	// Clear only once the counter is stopped
	task automatic stop_clear(input logic sel);
		access(OFS_COMMAND, {sel, 7'h08}, 1'b1);
		access(OFS_COMMAND, {sel, 7'h01}, 1'b1);
	endtask : stop_clear
endmodule : host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top import ctr_pkg::*; ;
	logic                  sys_clk;                 // 100 MHz clock
	logic                  resetn;                  // Reset, low
	logic [ADDR_WIDTH-1:0] io_addr;                 // Bus offset
	logic [DATA_WIDTH-1:0] io_wdata;                // Bus write data
	logic                  io_wr;                   // Write strobe
	logic                  io_rd;                   // Read strobe
	logic                  pacer_gate;              // Pacer gate level
	logic                  gp_gate;                 // General gate level
	logic [DATA_WIDTH-1:0] io_rdata_q;              // Read data
	logic                  pacer_pulse;             // Pacer output
	logic                  gp_pulse;                // General output
	logic                  psel;                    // Pulse being watched
	logic                  rd_pend = 1'b0;          // Read answer due
	logic [31:0]           rng_q   = 32'hb58e3fec;  // Random state
	logic [7:0]            exp_q[$];                // Expected read bytes
	int                    n_errors    = 0;         // Mismatches
	int                    checks_done = 0;         // Comparisons
	wire                   cur_pulse = psel ? gp_pulse : pacer_pulse; // Watched pulse

	ctr_cmd_port i_dut (.sys_clk(sys_clk), .resetn(resetn), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .pacer_gate(pacer_gate),
		.gp_gate(gp_gate), .io_rdata_q(io_rdata_q), .pacer_pulse(pacer_pulse),
		.gp_pulse(gp_pulse));
	host_model i_host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_wr(io_wr), .io_rd(io_rd));

	// Free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Xorshift stream from a fixed seed
	function automatic logic [31:0] rand32();
		rng_q = rng_q ^ (rng_q << 13);
		rng_q = rng_q ^ (rng_q >> 17);
		rng_q = rng_q ^ (rng_q << 5);
		return rng_q;
	endfunction : rand32
	// Verdict and end of run
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	// Read data compare
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t read data %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte
	// Cycle count compare
	task automatic cmp_int(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			n_errors++;
			$display("[FAIL] %0t cycles %0d expected %0d", $time, got, exp);
		end
	endtask : cmp_int
	// Bus shorthands; reads note the expected byte first
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_host.access(a, d, 1'b1);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		i_host.access(a, 8'h00, 1'b0);
	endtask : rd
	// Stage bytes high, low, middle to show order does not matter
	task automatic stage(input logic [23:0] v);
		wr(OFS_DATA_HIGH, v[23:16]);
		wr(OFS_DATA_LOW, v[7:0]);
		wr(OFS_DATA_MID, v[15:8]);
	endtask : stage
	// Read back a latched value; high byte is zero for the general counter
	task automatic reads_chk(input logic sel, input logic [23:0] v);
		rd(OFS_DATA_LOW, v[7:0]);
		rd(OFS_DATA_MID, v[15:8]);
		rd(OFS_DATA_HIGH, sel ? 8'h00 : v[23:16]);
	endtask : reads_chk
	// Bounded wait until the watched pulse rises
	task automatic wait_rise();
		int k;
		k = 0;
		while (cur_pulse === 1'b1 && k < 5000) begin
			@(negedge sys_clk);
			k++;
		end
		while (cur_pulse !== 1'b1 && k < 5000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 5000) begin
			n_errors++;
			$display("[FAIL] %0t no pulse seen", $time);
		end
	endtask : wait_rise
	// Width and period of one full pulse after resynchronising
	task automatic pulse_chk(input logic sel, input int per, input int wid);
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		psel = sel;
		repeat (2) wait_rise();
		while (cur_pulse === 1'b1 && hi < 5000) begin
			@(negedge sys_clk);
			hi++;
		end
		while (cur_pulse !== 1'b1 && lo < 5000) begin
			@(negedge sys_clk);
			lo++;
		end
		cmp_int(hi, wid);
		cmp_int(hi + lo, per);
	endtask : pulse_chk
	// No rising pulse over a stretch; a held-high pulse is not a rise
	task automatic no_pulse(input logic sel);
		int r;
		logic pv;
		r = 0;
		psel = sel;
		repeat (5) @(negedge sys_clk);
		pv = cur_pulse;
		repeat (400) begin
			@(negedge sys_clk);
			if (cur_pulse === 1'b1 && pv !== 1'b1) r++;
			pv = cur_pulse;
		end
		cmp_int(r, 0);
	endtask : no_pulse
	// Answer monitor: one cycle after a read edge, compare the oldest note
	always @(posedge sys_clk) rd_pend <= io_rd;
	always @(negedge sys_clk) begin
		if (rd_pend === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("[FAIL] %0t unexpected read", $time);
			end else begin
				cmp_byte(io_rdata_q, exp_q.pop_front());
			end
		end
	end
	// Watchdog, far beyond the expected run length
	initial begin
		#500000;
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [23:0] nv;
		logic        sel;
		int          n;
		resetn     = 1'b0;
		pacer_gate = 1'b0;
		gp_gate    = 1'b0;
		psel       = 1'b0;
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		// Reset value and write-only or unmapped offsets
		rd(OFS_DATA_LOW, RDATA_RESET);
		rd(OFS_COMMAND, UNMAPPED_DATA);
		rd(OFS_RATE, UNMAPPED_DATA);
		// Staged bytes any order, load, latch
		stage(24'h123456);
		wr(OFS_COMMAND, 8'h02);
		wr(OFS_COMMAND, 8'h40);
		reads_chk(SEL_PACER, 24'h123456);
		// Random values, load and latch in one byte, both counters
		for (int i = 0; i < 4; i++) begin
			r = rand32();
			sel = r[24];
			stage(r[23:0]);
			wr(OFS_COMMAND, {sel, 7'h42});
			reads_chk(sel, sel ? {8'h00, r[15:0]} : r[23:0]);
		end
		// Load then clear in one byte leaves zero
		wr(OFS_COMMAND, 8'hc3);
		reads_chk(SEL_GP, 24'h000000);
		// Disabled since reset: value held across many ticks
		r = rand32();
		nv = 24'h000002 + {21'h0, r[2:0]};
		n = int'(nv);
		stage(nv);
		wr(OFS_COMMAND, 8'h02);
		repeat (300) @(negedge sys_clk);
		wr(OFS_COMMAND, 8'h40);
		reads_chk(SEL_PACER, nv);
		// Divide by n on the fast clock
		i_host.start(SEL_PACER, 1'b0);
		pulse_chk(SEL_PACER, n * 10, 10);
		// Latch while running, and run with stop cancel each other
		wr(OFS_COMMAND, 8'h40);
		wr(OFS_COMMAND, 8'h0c);
		pulse_chk(SEL_PACER, n * 10, 10);
		// Slow clock by the rate bit
		wr(OFS_RATE, 8'h08);
		pulse_chk(SEL_PACER, n * 100, 100);
		wr(OFS_RATE, 8'h00);
		// Gating: low gate stops counting; opposing gate bits do nothing
		wr(OFS_COMMAND, 8'h10);
		no_pulse(SEL_PACER);
		wr(OFS_COMMAND, 8'h30);
		no_pulse(SEL_PACER);
		pacer_gate = 1'b1;
		pulse_chk(SEL_PACER, n * 10, 10);
		pacer_gate = 1'b0;
		wr(OFS_COMMAND, 8'h20);
		pulse_chk(SEL_PACER, n * 10, 10);
		// Stopped and cleared: zero that stays
		i_host.stop_clear(SEL_PACER);
		wr(OFS_COMMAND, 8'h40);
		reads_chk(SEL_PACER, 24'h000000);
		repeat (100) @(negedge sys_clk);
		wr(OFS_COMMAND, 8'h40);
		reads_chk(SEL_PACER, 24'h000000);
		// Clear with enable: keeps counting from the reload value
		wr(OFS_COMMAND, 8'h05);
		pulse_chk(SEL_PACER, n * 10, 10);
		// General counter, gated
		stage(24'h000004);
		i_host.start(SEL_GP, 1'b1);
		no_pulse(SEL_GP);
		gp_gate = 1'b1;
		pulse_chk(SEL_GP, 40, 10);
		// Gate off on the general counter: counts with gate low
		gp_gate = 1'b0;
		wr(OFS_COMMAND, 8'ha0);
		pulse_chk(SEL_GP, 40, 10);
		// Stop, clear, then a plain latch of the general counter
		i_host.stop_clear(SEL_GP);
		wr(OFS_COMMAND, 8'hc0);
		reads_chk(SEL_GP, 24'h000000);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
